/* File: hw/lcc_command_flags.v */
// Command mailbox, sticky flags and latched driver faults of the lens cleaner.
`timescale 1ns/1ps
`default_nettype none
`include "lcc_defs.vh"

module lcc_command_flags #(
	parameter [6:0] TARGET_ADDR = 7'h48,
	parameter integer CMD_EXEC_CYCLES = `LCC_CMD_EXEC_TIME_US * `LCC_CLK_MHZ,
	parameter integer CNT_W = 18
) (
	// Clock and reset.
	input wire sys_clk,
	input wire rst_b,
	// I2C pins, SDA open drain.
	input wire scl,
	input wire sdaIn,
	output wire sdaOut,
	output wire sdaOe,
	// Measurements from the drive path.
	input wire measValid,
	input wire [7:0] measPower,
	input wire [7:0] measCurrent,
	input wire [7:0] measTemp,
	// Diagnostic mode result.
	input wire diagDone,
	input wire diagMechFail,
	// External driver fault lines.
	input wire driverFault,
	input wire secondDriverFault,
	// Status to the rest of the device.
	output reg activeMode,
	output reg commandBusy,
	output reg reinitPulse
);

	// ****************************************
	// Register state
	// ****************************************

	reg [7:0] pageSelect; // Current page.
	reg [7:0] bookSelect; // Current book.
	reg [7:0] powerControl; // Power mode register.
	reg [7:0] intClkCfg; // Interrupt and clock configuration, bit 2 not stored.
	// Mailbox words of the user page.
	reg [31:0] hostCommand; // Command code written by the host.
	reg [31:0] commandPending; // Nonzero while a command is due or running.
	reg [31:0] runCode; // Code captured at launch.
	reg [7:0] regPtr; // Register pointer, auto-increments.
	reg [7:0] rdData; // Byte handed to the bus engine.
	reg [CNT_W-1:0] execCnt; // Cycles left in the running command.
	// Order: upper power, lower power, over temperature, minimum current.
	reg [7:0] bufThresh [0:3]; // Host-written threshold buffer.
	reg [7:0] opThresh [0:3]; // Operating thresholds in use.
	// Helpers of the combinational read path.
	reg [7:0] readByte; // Byte at the pointer, combinational.
	reg [31:0] wordSel; // Word containing the pointer, combinational.
	reg clearFwFlags; // One-cycle clear of the firmware flags.

	// Byte strobes and data from the bus engine; wrStrobe and rdReq last one cycle each.
	wire wrStrobe;
	wire wrFirst;
	wire [7:0] wrData;
	wire rdReq;
	// Pin drive, passed straight to the ports.
	wire sdaOutNet;
	wire sdaOeNet;
	wire [4:0] fwFlag; // Open load, over power, over temp, system fault, under power.
	wire [1:0] hwLatch; // Driver fault, second driver fault.

	// Decoding of the pointer into page and word.
	// Only book 0 maps registers beyond the two select bytes.
	wire inMainBook = (bookSelect == `LCC_BOOK_MAIN);
	wire onCtrlPage = inMainBook && (pageSelect == `LCC_PAGE_CTRL);
	wire onLatchPage = inMainBook && (pageSelect == `LCC_PAGE_LATCH);
	wire onUserPage = inMainBook && (pageSelect == `LCC_PAGE_USER);
	wire [7:0] wordAddr = {regPtr[7:2], 2'b00};
	wire [1:0] byteSel = regPtr[1:0];
	// A strobe, not a stored bit: the clear acts on the written byte.
	wire hwClear = wrStrobe && !wrFirst && onCtrlPage && (regPtr == `LCC_OFS_INT_CLK_CFG)
		&& wrData[`LCC_INT_CLK_CFG_CLEAR_BIT];
	// A command set in shutdown waits here until active mode.
	wire launch = (commandPending != 32'h00000000) && !commandBusy && activeMode;
	// The counter reads zero in the last busy cycle.
	wire execDone = commandBusy && (execCnt == {CNT_W{1'b0}});

	// ****************************************
	// Bus engine
	// ****************************************

	// The byte engine handles framing; this module owns the register map.
	// The address is a parameter so several blocks can share a bus.
	lcc_i2c_target #(
		.TARGET_ADDR(TARGET_ADDR)
	) u_target (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.scl(scl),
		.sdaIn(sdaIn),
		.sdaOut(sdaOutNet),
		.sdaOe(sdaOeNet),
		.wrStrobe(wrStrobe),
		.wrFirst(wrFirst),
		.wrData(wrData),
		.rdReq(rdReq),
		.rdData(rdData)
	);

	// The enable is high while the block pulls the data line low.
	assign sdaOut = sdaOutNet;
	assign sdaOe = sdaOeNet;

	// ****************************************
	// Sticky flags
	// ****************************************

	// Firmware flags, cleared only by the clear command.
	// Comparisons are strict: a value at a threshold raises nothing.
	// Open load: current below the minimum.
	lcc_sticky_flag u_open_load (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.setEvent(measValid && (measCurrent < opThresh[3])),
		.clearEvent(clearFwFlags),
		.flag(fwFlag[0])
	);

	// Over power: power above the upper threshold.
	lcc_sticky_flag u_over_power (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.setEvent(measValid && (measPower > opThresh[0])),
		.clearEvent(clearFwFlags),
		.flag(fwFlag[1])
	);

	// Over temperature: lens cover above its threshold.
	lcc_sticky_flag u_over_temp (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.setEvent(measValid && (measTemp > opThresh[2])),
		.clearEvent(clearFwFlags),
		.flag(fwFlag[2])
	);

	// System fault: diagnostic found a failed lens cover assembly.
	lcc_sticky_flag u_sys_fault (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.setEvent(diagDone && diagMechFail),
		.clearEvent(clearFwFlags),
		.flag(fwFlag[3])
	);

	// Under power: power below the lower threshold.
	lcc_sticky_flag u_under_power (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.setEvent(measValid && (measPower < opThresh[1])),
		.clearEvent(clearFwFlags),
		.flag(fwFlag[4])
	);

	// Hardware latches answer only to the configuration clear bit, never the command.
	lcc_sticky_flag u_drv_fault (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.setEvent(driverFault),
		.clearEvent(hwClear),
		.flag(hwLatch[0])
	);

	// Unused by the present driver, kept for a second fault source.
	lcc_sticky_flag u_drv2_fault (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.setEvent(secondDriverFault),
		.clearEvent(hwClear),
		.flag(hwLatch[1])
	);

	// ****************************************
	// Read multiplexer
	// ****************************************

	// Words are presented most significant byte first at the lowest address.
	always @* begin
		wordSel = 32'h00000000;
		readByte = 8'h00;
		if (onUserPage) begin
			case (wordAddr)
				`LCC_OFS_HOST_COMMAND: wordSel = hostCommand;
				`LCC_OFS_CMD_PENDING: wordSel = commandPending;
				`LCC_OFS_OPEN_LOAD: wordSel = {31'h0, fwFlag[0]};
				`LCC_OFS_OVER_POWER: wordSel = {31'h0, fwFlag[1]};
				`LCC_OFS_OVER_TEMP: wordSel = {31'h0, fwFlag[2]};
				`LCC_OFS_SYS_FAULT: wordSel = {31'h0, fwFlag[3]};
				`LCC_OFS_UNDER_POWER: wordSel = {31'h0, fwFlag[4]};
				`LCC_OFS_THRESHOLDS: wordSel = {bufThresh[0], bufThresh[1], bufThresh[2],
					bufThresh[3]};
				default: wordSel = 32'h00000000;
			endcase
			// The low pointer bits pick the byte within the word.
			case (byteSel)
				2'h0: readByte = wordSel[31:24];
				2'h1: readByte = wordSel[23:16];
				2'h2: readByte = wordSel[15:8];
				default: readByte = wordSel[7:0];
			endcase
		end
		// The page select sits at offset zero of every page and book.
		if (regPtr == `LCC_OFS_PAGE_SELECT) begin
			readByte = pageSelect;
		end else if (onCtrlPage) begin
			case (regPtr)
				`LCC_OFS_BOOK_SELECT: readByte = bookSelect;
				`LCC_OFS_POWER_CONTROL: readByte = powerControl;
				`LCC_OFS_INT_CLK_CFG: readByte = intClkCfg;
				default: readByte = 8'h00;
			endcase
		end else if (pageSelect == `LCC_PAGE_CTRL && regPtr == `LCC_OFS_BOOK_SELECT) begin
			readByte = bookSelect; // Lets the host return from another book.
		end else if (onLatchPage) begin
			// Besides the page select, only the latch register answers on this page.
			readByte = (regPtr == `LCC_OFS_LATCHED_INTS) ? {hwLatch, 6'h00} : 8'h00;
		end
	end

	// ****************************************
	// Register writes and command engine
	// ****************************************

	// Host writes and the command engine share one process so pending has one driver.
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			// Wake in shutdown on page 0 of book 0.
			pageSelect <= 8'h00;
			bookSelect <= 8'h00;
			powerControl <= `LCC_PWR_SHUTDOWN;
			intClkCfg <= `LCC_INT_CLK_CFG_RESET;
			hostCommand <= 32'h00000000;
			commandPending <= 32'h00000000;
			runCode <= 32'h00000000;
			regPtr <= 8'h00;
			rdData <= 8'h00;
			execCnt <= {CNT_W{1'b0}};
			commandBusy <= 1'b0;
			reinitPulse <= 1'b0;
			clearFwFlags <= 1'b0;
			activeMode <= 1'b0;
			// Buffer and operating copies start equal, so no reload is due.
			bufThresh[0] <= `LCC_UPPER_POWER_RESET;
			bufThresh[1] <= `LCC_LOWER_POWER_RESET;
			bufThresh[2] <= `LCC_OVER_TEMP_RESET;
			bufThresh[3] <= `LCC_MIN_CURRENT_RESET;
			opThresh[0] <= `LCC_UPPER_POWER_RESET;
			opThresh[1] <= `LCC_LOWER_POWER_RESET;
			opThresh[2] <= `LCC_OVER_TEMP_RESET;
			opThresh[3] <= `LCC_MIN_CURRENT_RESET;
		end else begin
			reinitPulse <= 1'b0;
			clearFwFlags <= 1'b0;
			// Active mode follows the power register one cycle later.
			activeMode <= (powerControl == `LCC_PWR_ACTIVE);
			// Reads hand the byte over and move the pointer on.
			if (rdReq) begin
				rdData <= readByte;
				regPtr <= regPtr + 8'h01;
			end
			// The first byte of a write frame only moves the pointer.
			if (wrStrobe && wrFirst) begin
				regPtr <= wrData;
			end else if (wrStrobe) begin
				// Data bytes land at the pointer, which then moves on.
				regPtr <= regPtr + 8'h01;
				if (regPtr == `LCC_OFS_PAGE_SELECT) begin
					pageSelect <= wrData;
				end else if (pageSelect == `LCC_PAGE_CTRL && regPtr == `LCC_OFS_BOOK_SELECT) begin
					bookSelect <= wrData;
				end else if (onCtrlPage && regPtr == `LCC_OFS_POWER_CONTROL) begin
					powerControl <= wrData;
				end else if (onCtrlPage && regPtr == `LCC_OFS_INT_CLK_CFG) begin
					// The clear bit acts once and is not stored.
					intClkCfg <= wrData & ~(8'h01 << `LCC_INT_CLK_CFG_CLEAR_BIT);
				end else if (onUserPage && wordAddr == `LCC_OFS_HOST_COMMAND
					&& commandPending == 32'h00000000) begin
					// Frozen while a command waits or runs, so it finishes as launched.
					hostCommand[8*(3-byteSel) +: 8] <= wrData;
				end else if (onUserPage && wordAddr == `LCC_OFS_CMD_PENDING && !commandBusy) begin
					// Blocked while busy, so a late write cannot undo completion.
					commandPending[8*(3-byteSel) +: 8] <= wrData;
				end else if (onUserPage && wordAddr == `LCC_OFS_THRESHOLDS) begin
					// Buffered only; operating values change on reinitialise.
					bufThresh[byteSel] <= wrData;
				end
			end
			// Launch only on a set pending word and only in active mode.
			if (launch) begin
				commandBusy <= 1'b1;
				// Captured here, so later writes cannot change the result.
				runCode <= hostCommand;
				execCnt <= CMD_EXEC_CYCLES[CNT_W-1:0] - {{(CNT_W-1){1'b0}}, 1'b1};
			end else if (execDone) begin
				commandBusy <= 1'b0;
				commandPending <= 32'h00000000;
				// Unknown codes finish with no side effect.
				if (runCode == `LCC_CMD_REINIT) begin
					opThresh[0] <= bufThresh[0];
					opThresh[1] <= bufThresh[1];
					opThresh[2] <= bufThresh[2];
					opThresh[3] <= bufThresh[3];
					reinitPulse <= 1'b1;
				end else if (runCode == `LCC_CMD_CLEAR_FLAGS) begin
					clearFwFlags <= 1'b1;
				end
			end else if (commandBusy) begin
				// Count down towards completion.
				execCnt <= execCnt - {{(CNT_W-1){1'b0}}, 1'b1};
			end
		end
	end

endmodule // lcc_command_flags

`default_nettype wire

/* File: hw/lcc_i2c_target.v */
// Byte-level I2C target: turns bus traffic into write strobes and read requests.
`timescale 1ns/1ps
`default_nettype none

module lcc_i2c_target #(
	parameter [6:0] TARGET_ADDR = 7'h48
) (
	// Clock and reset.
	input wire sys_clk,
	input wire rst_b,
	// Bus pins, SDA open drain.
	input wire scl,
	input wire sdaIn,
	output reg sdaOut,
	output reg sdaOe,
	// Byte side.
	output reg wrStrobe,
	output reg wrFirst,
	output reg [7:0] wrData,
	output reg rdReq,
	input wire [7:0] rdData
);

	// ****************************************
	// Bus states
	// ****************************************

	localparam [2:0] ST_IDLE = 3'h0;
	localparam [2:0] ST_ADDR = 3'h1;
	localparam [2:0] ST_ADDR_ACK = 3'h2;
	localparam [2:0] ST_RECV = 3'h3;
	localparam [2:0] ST_RECV_ACK = 3'h4;
	localparam [2:0] ST_SEND = 3'h5;
	localparam [2:0] ST_SEND_ACK = 3'h6;
	localparam [2:0] ST_SEND_LOAD = 3'h7;

	reg sclPrev; // SCL one cycle ago.
	reg sdaPrev; // SDA one cycle ago.
	reg [2:0] state; // Bus state.
	reg [2:0] bitCnt; // Bit within the byte, wraps after eight.
	reg [7:0] shiftReg; // Byte being shifted.
	reg isRead; // Transfer direction from the address byte.
	reg firstPending; // Next written byte is the register pointer.

	wire sclRise = ~sclPrev & scl;
	wire sclFall = sclPrev & ~scl;
	wire startCond = sclPrev & scl & sdaPrev & ~sdaIn;
	wire stopCond = sclPrev & scl & ~sdaPrev & sdaIn;
	wire [7:0] nextShift = {shiftReg[6:0], sdaIn};

	// ****************************************
	// Bus engine
	// ****************************************

	// Start and stop win over any byte in progress, matching bus recovery practice.
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			sclPrev <= 1'b1;
			sdaPrev <= 1'b1;
			state <= ST_IDLE;
			bitCnt <= 3'h0;
			shiftReg <= 8'h00;
			isRead <= 1'b0;
			firstPending <= 1'b0;
			sdaOut <= 1'b0;
			sdaOe <= 1'b0;
			wrStrobe <= 1'b0;
			wrFirst <= 1'b0;
			wrData <= 8'h00;
			rdReq <= 1'b0;
		end else begin
			sclPrev <= scl;
			sdaPrev <= sdaIn;
			sdaOut <= 1'b0;
			wrStrobe <= 1'b0;
			rdReq <= 1'b0;
			if (startCond) begin
				state <= ST_ADDR;
				bitCnt <= 3'h0;
				sdaOe <= 1'b0;
			end else if (stopCond) begin
				state <= ST_IDLE;
				sdaOe <= 1'b0;
			end else begin
				case (state)
					ST_ADDR: if (sclRise) begin
						shiftReg <= nextShift;
						bitCnt <= bitCnt + 3'h1;
						if (bitCnt == 3'h7) begin
							if (nextShift[7:1] == TARGET_ADDR) begin
								state <= ST_ADDR_ACK;
								isRead <= nextShift[0];
								firstPending <= 1'b1;
								rdReq <= nextShift[0];
							end else begin
								state <= ST_IDLE;
							end
						end
					end
					ST_ADDR_ACK: if (sclFall) begin
						if (!sdaOe) begin
							sdaOe <= 1'b1;
						end else if (isRead) begin
							state <= ST_SEND;
							shiftReg <= rdData;
							sdaOe <= ~rdData[7];
						end else begin
							state <= ST_RECV;
							sdaOe <= 1'b0;
						end
					end
					ST_RECV: if (sclRise) begin
						shiftReg <= nextShift;
						bitCnt <= bitCnt + 3'h1;
						if (bitCnt == 3'h7) begin
							wrStrobe <= 1'b1;
							wrData <= nextShift;
							wrFirst <= firstPending;
							firstPending <= 1'b0;
							state <= ST_RECV_ACK;
						end
					end
					ST_RECV_ACK: if (sclFall) begin
						if (!sdaOe) begin
							sdaOe <= 1'b1;
						end else begin
							sdaOe <= 1'b0;
							state <= ST_RECV;
						end
					end
					ST_SEND: if (sclFall) begin
						bitCnt <= bitCnt + 3'h1;
						shiftReg <= {shiftReg[6:0], 1'b0};
						if (bitCnt == 3'h7) begin
							sdaOe <= 1'b0;
							state <= ST_SEND_ACK;
						end else begin
							sdaOe <= ~shiftReg[6];
						end
					end
					ST_SEND_ACK: if (sclRise) begin
						if (sdaIn) begin
							state <= ST_IDLE;
						end else begin
							rdReq <= 1'b1;
							state <= ST_SEND_LOAD;
						end
					end
					ST_SEND_LOAD: if (sclFall) begin
						shiftReg <= rdData;
						sdaOe <= ~rdData[7];
						state <= ST_SEND;
					end
					default: begin
						state <= ST_IDLE;
					end
				endcase
			end
		end
	end

endmodule // lcc_i2c_target

`default_nettype wire

/* File: hw/lcc_sticky_flag.v */
// Sticky flag cell: set by an event, held until cleared, set wins over clear.
`timescale 1ns/1ps
`default_nettype none

module lcc_sticky_flag (
	// Clock and reset.
	input wire sys_clk,
	input wire rst_b,
	// Event and clear.
	input wire setEvent,
	input wire clearEvent,
	// Held flag.
	output reg flag
);

	// ****************************************
	// Flag storage
	// ****************************************

	// An event in the same cycle as a clear survives, so nothing is lost.
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			flag <= 1'b0;
		end else if (setEvent) begin
			flag <= 1'b1;
		end else if (clearEvent) begin
			flag <= 1'b0;
		end
	end

endmodule // lcc_sticky_flag

`default_nettype wire

/* File: include/lcc_defs.vh */
// Constants for the lens cleaner command mailbox and flag block.
`ifndef LCC_DEFS_VH
`define LCC_DEFS_VH

// Book and page selection.
`define LCC_OFS_PAGE_SELECT 8'h00
`define LCC_OFS_BOOK_SELECT 8'h7F
`define LCC_BOOK_MAIN 8'h00
`define LCC_PAGE_CTRL 8'h00
`define LCC_PAGE_LATCH 8'h02
`define LCC_PAGE_USER 8'h1A

// Page 0 registers.
`define LCC_OFS_POWER_CONTROL 8'h02
`define LCC_PWR_ACTIVE 8'h00
`define LCC_PWR_SHUTDOWN 8'h02
`define LCC_OFS_INT_CLK_CFG 8'h30
`define LCC_INT_CLK_CFG_RESET 8'h01
`define LCC_INT_CLK_CFG_CLEAR_BIT 2

// Page 2 register and its latch bits.
`define LCC_OFS_LATCHED_INTS 8'h34
`define LCC_LATCH_DRV_FAULT_BIT 6
`define LCC_LATCH_DRV2_FAULT_BIT 7

// Page 0x1A words, each occupying four byte addresses, most significant first.
`define LCC_OFS_HOST_COMMAND 8'h58
`define LCC_OFS_CMD_PENDING 8'h5C
`define LCC_OFS_OPEN_LOAD 8'h60
`define LCC_OFS_OVER_POWER 8'h64
`define LCC_OFS_OVER_TEMP 8'h68
`define LCC_OFS_SYS_FAULT 8'h6C
`define LCC_OFS_UNDER_POWER 8'h70
`define LCC_OFS_THRESHOLDS 8'h74

// Command codes.
`define LCC_CMD_CLEAR_FLAGS 32'h0000000D
`define LCC_CMD_REINIT 32'h0000000E

// Threshold buffer reset values.
`define LCC_UPPER_POWER_RESET 8'hC0
`define LCC_LOWER_POWER_RESET 8'h20
`define LCC_OVER_TEMP_RESET 8'hA0
`define LCC_MIN_CURRENT_RESET 8'h10

// Timing.
`define LCC_CLK_MHZ 50
`define LCC_CMD_EXEC_TIME_US 5000

`endif

/* File: tb/lcc_command_flags_asserts.sv */
// Port-level checks of the command mailbox and flag block.
`timescale 1ns/1ps
`default_nettype none

module lcc_command_flags_asserts #(
	parameter integer CMD_EXEC_CYCLES = 20
) (
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic rst_b,
	// Bus pins.
	input wire logic scl,
	input wire logic sdaOut,
	input wire logic sdaOe,
	// Status.
	input wire logic activeMode,
	input wire logic commandBusy,
	input wire logic reinitPulse
);
	// ****
	// Helpers
	// ****
	// Allow one cycle either way, since the busy edges are registered.
	localparam int LEN_LO = CMD_EXEC_CYCLES - 1;
	localparam int LEN_HI = CMD_EXEC_CYCLES + 1;
	int busyLen; // Cycles the present command has been running.

	// Counts the busy run so that its length can be judged at the end.
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b)
			busyLen <= 0;
		else
			busyLen <= commandBusy ? busyLen + 1 : 0;
	end

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_b);

	// ****
	// Checks
	// ****
	a_busy_start_active: assert property ($rose(commandBusy) |-> activeMode)
		else $error("command started while shut down");
	a_busy_length: assert property ($fell(commandBusy) |-> busyLen inside {[LEN_LO:LEN_HI]})
		else $error("command run time wrong");
	a_busy_rest: assert property ($fell(commandBusy) |-> !commandBusy [*8])
		else $error("command restarted without a new launch");
	a_reinit_after_busy: assert property (reinitPulse |-> !commandBusy &&
		($past(commandBusy) || $past(commandBusy, 2)))
		else $error("reload pulse not at command end");
	a_reinit_single: assert property (reinitPulse |=> !reinitPulse)
		else $error("reload pulse longer than one cycle");
	a_sda_steady: assert property (scl && $past(scl) |-> $stable(sdaOe))
		else $error("data line moved while clock high");
	a_sda_low_only: assert property (sdaOe |-> !sdaOut)
		else $error("data line driven high");
	a_active_on_write: assert property ($changed(activeMode) |-> scl)
		else $error("power mode changed outside a bus write");

	// Main scenarios reached.
	c_reinit: cover property (reinitPulse);
	c_busy_end: cover property ($fell(commandBusy));
	c_ack: cover property ($rose(sdaOe));
endmodule // lcc_command_flags_asserts

bind lcc_command_flags lcc_command_flags_asserts #(
	.CMD_EXEC_CYCLES(CMD_EXEC_CYCLES)
) i_lcc_command_flags_asserts (
	.sys_clk(sys_clk),
	.rst_b(rst_b),
	.scl(scl),
	.sdaOut(sdaOut),
	.sdaOe(sdaOe),
	.activeMode(activeMode),
	.commandBusy(commandBusy),
	.reinitPulse(reinitPulse)
);
`default_nettype wire

/* File: tb/lcc_host_model.sv */
// Host controller model driving the two-wire register bus.
`timescale 1ns/1ps
`default_nettype none

module lcc_host_model (
	// Clock.
	input wire logic sys_clk,
	// Bus lines; sdaPull high pulls the data line low.
	output logic scl,
	output logic sdaPull,
	input wire logic sdaLine
);
	int nacks = 0; // Bytes the device failed to acknowledge.
	logic [6:0] addr = 7'h48; // Bench may change it to test refusal.

	// Clock driven high and data line released to the pull-up, so both stay high between frames.
	initial begin
		scl = 1'b1;
		sdaPull = 1'b0;
	end

	// ****
	// Bit level
	// ****
	// Half periods of five cycles leave the target room to sample.
	task automatic tick(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	task automatic bitOut(input logic v);
		sdaPull = !v;
		tick(5);
		scl = 1'b1;
		tick(5);
		scl = 1'b0;
	endtask
	task automatic bitIn(output logic v);
		sdaPull = 1'b0;
		tick(5);
		scl = 1'b1;
		tick(3);
		v = sdaLine;
		tick(2);
		scl = 1'b0;
	endtask
	task automatic byteOut(input logic [7:0] d);
		logic ack;
		for (int i = 7; i >= 0; i--)
			bitOut(d[i]);
		bitIn(ack);
		if (ack !== 1'b0)
			nacks++;
	endtask
	task automatic start(input logic rd);
		tick(5);
		sdaPull = 1'b1;
		tick(5);
		scl = 1'b0;
		byteOut({addr, rd});
	endtask
	task automatic stop();
		sdaPull = 1'b1;
		tick(5);
		scl = 1'b1;
		tick(5);
		sdaPull = 1'b0;
		tick(5);
	endtask

	// ****
	// Register level
	// ****
	task automatic wrBytes(input logic [7:0] ofs, input logic [7:0] d[$]);
		start(1'b0);
		byteOut(ofs);
		foreach (d[i])
			byteOut(d[i]);
		stop();
	endtask
	// Sets the pointer in its own frame, then reads; last byte is refused.
	task automatic rdBytes(input logic [7:0] ofs, input int n, output logic [7:0] q[$]);
		logic [7:0] v;
		q = {};
		start(1'b0);
		byteOut(ofs);
		stop();
		start(1'b1);
		for (int k = 0; k < n; k++) begin
			for (int i = 7; i >= 0; i--)
				bitIn(v[i]);
			bitOut(k == n - 1);
			q.push_back(v);
		end
		stop();
	endtask
endmodule // lcc_host_model
`default_nettype wire

/* File: tb/tb_lcc_command_flags.sv */
// Self-checking bench of the command mailbox and flag block.
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) \
	begin \
	comparisons++; \
	if ((g) !== (e)) begin \
	n_errors++; \
	$display("[FAIL] %s expected %h seen %h", nm, e, g); \
	end \
	end

module tb_lcc_command_flags;
	// ****
	// Signals
	// ****
	localparam int EXEC = 2000; // Shortened command time, long enough to write during it.
	logic sys_clk = 1'b0;
	logic rst_b = 1'b0;
	wire scl;
	wire hostPull;
	wire sdaLine;
	wire sdaOut;
	wire sdaOe;
	wire activeMode;
	wire commandBusy;
	wire reinitPulse;
	logic measValid = 1'b0;
	logic [7:0] measPower = 8'h00;
	logic [7:0] measCurrent = 8'h00;
	logic [7:0] measTemp = 8'h00;
	logic diagDone = 1'b0;
	logic diagMechFail = 1'b0;
	logic driverFault = 1'b0;
	logic secondDriverFault = 1'b0;
	int n_errors = 0;
	int comparisons = 0;
	int reinits = 0; // Reload pulses seen.
	// Thresholds in force: upper, lower power, temperature, current.
	logic [7:0] upper = 8'hC0;
	logic [7:0] lower = 8'h20;
	logic [7:0] hot = 8'hA0;
	logic [7:0] minCur = 8'h10;
	logic [4:0] expF = 5'h00; // Expected flags, bit k at word 0x60 + 4k.
	logic [31:0] r;
	logic [7:0] b;

	// Open-drain data line: low if anyone pulls.
	assign sdaLine = !(hostPull || sdaOe);
	always #10 sys_clk = ~sys_clk;
	always @(negedge sys_clk)
		if (reinitPulse === 1'b1) reinits++;

	lcc_command_flags #(.CMD_EXEC_CYCLES(EXEC)) i_lcc_command_flags (
		.sys_clk(sys_clk), .rst_b(rst_b), .scl(scl), .sdaIn(sdaLine),
		.sdaOut(sdaOut), .sdaOe(sdaOe), .measValid(measValid),
		.measPower(measPower), .measCurrent(measCurrent), .measTemp(measTemp),
		.diagDone(diagDone), .diagMechFail(diagMechFail), .driverFault(driverFault),
		.secondDriverFault(secondDriverFault), .activeMode(activeMode),
		.commandBusy(commandBusy), .reinitPulse(reinitPulse));
	lcc_host_model i_lcc_host_model (.sys_clk(sys_clk), .scl(scl), .sdaPull(hostPull),
		.sdaLine(sdaLine));

	// ****
	// Tasks
	// ****
	task automatic print_verdict();
		if (n_errors == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic wr8(input logic [7:0] ofs, input logic [7:0] v);
		i_lcc_host_model.wrBytes(ofs, {v});
	endtask
	task automatic wr32(input logic [7:0] ofs, input logic [31:0] v);
		i_lcc_host_model.wrBytes(ofs, {v[31:24], v[23:16], v[15:8], v[7:0]});
	endtask
	task automatic rd8(input logic [7:0] ofs, output logic [7:0] v);
		logic [7:0] q[$];
		i_lcc_host_model.rdBytes(ofs, 1, q);
		v = q[0];
	endtask
	task automatic rd32(input logic [7:0] ofs, output logic [31:0] v);
		logic [7:0] q[$];
		i_lcc_host_model.rdBytes(ofs, 4, q);
		v = {q[0], q[1], q[2], q[3]};
	endtask
	// Flags a measurement should raise under the thresholds in force.
	function automatic logic [4:0] measFlags(input logic [7:0] p, c, t);
		return {p < lower, 1'b0, t > hot, p > upper, c < minCur};
	endfunction
	task automatic meas(input logic [7:0] p, c, t);
		{measPower, measCurrent, measTemp, measValid} = {p, c, t, 1'b1};
		expF = expF | measFlags(p, c, t);
		@(negedge sys_clk);
		measValid = 1'b0;
	endtask
	task automatic diag(input logic fail);
		{diagDone, diagMechFail} = {1'b1, fail};
		expF[3] = expF[3] | fail;
		@(negedge sys_clk);
		diagDone = 1'b0;
	endtask
	task automatic checkFlags();
		for (int k = 0; k < 5; k++) begin
			rd32(8'h60 + 8'(4 * k), r);
			`CHK("flag word", {31'h0, expF[k]}, r)
		end
	endtask
	// Bounded wait for the busy level; running out ends the run.
	task automatic waitBusy(input logic lvl);
		int k;
		for (k = 0; k < EXEC + 100 && commandBusy !== lvl; k++)
			@(negedge sys_clk);
		if (k == EXEC + 100) begin
			`CHK("busy wait", lvl, commandBusy)
			print_verdict();
		end
	endtask
	task automatic runCmd(input logic [31:0] code);
		wr32(8'h58, code);
		wr32(8'h5C, 32'h1);
		waitBusy(1'b1);
		waitBusy(1'b0);
		rd32(8'h5C, r);
		`CHK("pending word", 32'h0, r)
	endtask

	// ****
	// Sequence
	// ****
	initial begin
		void'($urandom(32'h6c5b1f7b));
		repeat (6) @(negedge sys_clk);
		rst_b = 1'b1;
		wr8(8'h00, 8'h00);
		// Another book maps nothing but the two select bytes.
		wr8(8'h7F, 8'h01);
		rd8(8'h02, b);
		`CHK("foreign book", 8'h00, b)
		wr8(8'h7F, 8'h00);
		rd8(8'h30, b);
		`CHK("int clock config", 8'h01, b)
		rd8(8'h02, b);
		`CHK("power control", 8'h02, b)
		`CHK("active mode", 1'b0, activeMode)
		rd8(8'h10, b);
		`CHK("unmapped byte", 8'h00, b)
		wr8(8'h02, 8'h00);
		`CHK("active mode", 1'b1, activeMode)
		repeat (EXEC) @(negedge sys_clk);
		wr8(8'h00, 8'h1A);
		// New thresholds wait in the buffer until a re-initialise.
		wr32(8'h74, 32'h90408030);
		meas(8'h98, 8'h20, 8'h90);
		checkFlags();
		runCmd(32'h0000000E);
		`CHK("reload count", 1, reinits)
		{upper, lower, hot, minCur} = 32'h90408030;
		// Values at the thresholds themselves raise nothing.
		meas(upper, minCur, hot);
		meas(lower, 8'hFF, 8'h00);
		diag(1'b0);
		checkFlags();
		meas(8'h98, 8'h20, 8'h90);
		for (int k = 0; k < 12; k++)
			meas(8'($urandom()), 8'($urandom()), 8'($urandom()));
		diag(1'b1);
		checkFlags();
		driverFault = 1'b1;
		@(negedge sys_clk);
		driverFault = 1'b0;
		wr8(8'h00, 8'h02);
		rd8(8'h34, b);
		`CHK("fault latch", 8'h40, b)
		secondDriverFault = 1'b1;
		@(negedge sys_clk);
		secondDriverFault = 1'b0;
		rd8(8'h34, b);
		`CHK("fault latch", 8'hC0, b)
		wr8(8'h00, 8'h1A);
		runCmd(32'h0000000D);
		expF = 5'h00;
		checkFlags();
		wr8(8'h00, 8'h02);
		rd8(8'h34, b);
		`CHK("fault latch", 8'hC0, b)
		wr8(8'h00, 8'h00);
		wr8(8'h30, 8'h05);
		rd8(8'h30, b);
		`CHK("int clock config", 8'h01, b)
		wr8(8'h00, 8'h02);
		rd8(8'h34, b);
		`CHK("fault latch", 8'h00, b)
		// A launch in shutdown waits, and its code stays frozen.
		wr8(8'h00, 8'h00);
		wr8(8'h02, 8'h02);
		`CHK("active mode", 1'b0, activeMode)
		meas(8'hFF, 8'hFF, 8'h00);
		wr8(8'h00, 8'h1A);
		wr32(8'h58, 32'h0000000D);
		wr32(8'h5C, 32'h1);
		wr32(8'h58, 32'h0000000E);
		rd32(8'h58, r);
		`CHK("command word", 32'h0000000D, r)
		rd32(8'h5C, r);
		`CHK("pending word", 32'h1, r)
		`CHK("busy", 1'b0, commandBusy)
		wr8(8'h00, 8'h00);
		wr8(8'h02, 8'h00);
		waitBusy(1'b1);
		waitBusy(1'b0);
		wr8(8'h00, 8'h1A);
		expF = 5'h00;
		checkFlags();
		`CHK("reload count", 1, reinits)
		// A foreign address gets no acknowledge.
		i_lcc_host_model.addr = 7'h49;
		wr8(8'h00, 8'h00);
		`CHK("missed acks", 3, i_lcc_host_model.nacks)
		print_verdict();
	end
endmodule // tb_lcc_command_flags
`default_nettype wire
